/* bench/clock_select_asserts.sv */
// Port assertions for the system clock selector.
`timescale 1ns/1ps
`default_nettype none
module clock_select_asserts (
  input wire logic clock,
  input wire logic srst,
  input wire logic rc_osc_in,
  input wire logic xtal_osc_in,
  input wire logic xtal_amp_ok,
  input wire logic lf_rc_in,
  input wire logic lf_ext_in,
  input wire clock_select_pkg::wake_mode_t wake_mode,
  input wire logic cal_load,
  input wire logic [7:0] cal_trim,
  input wire clock_select_pkg::clk_out_t clk_out,
  input wire clock_select_pkg::clk_status_t status,
  input wire logic [7:0] rc_trim
);
  default clocking @(posedge clock);
  endclocking
  default disable iff (srst);
  sequence xtal_taken;
    $rose(status.hs_on_xtal);
  endsequence
  a_reset_on_rc: assert property (
    $fell(srst) |-> !status.hs_on_xtal && !status.xtal_enable && !status.lf_on_ext) else $error("bad reset state");
  a_lf_sticky: assert property (
    status.lf_on_ext |=> status.lf_on_ext) else $error("lf source lost");
  a_stay_no_xtal: assert property (
    $rose(status.xtal_enable) |-> $past(wake_mode) inside {clock_select_pkg::WAKE_AUTO, clock_select_pkg::WAKE_MANUAL})
    else $error("xtal wanted in stay mode");
  a_amp_checked: assert property (
    xtal_taken |-> $past(xtal_amp_ok, 2) && $past(status.xtal_enable)) else $error("xtal without amplitude");
  a_switch_safe: assert property (
    xtal_taken |-> !$past(rc_osc_in) && !$past(xtal_osc_in) && !$past(clk_out.radio)) else $error("unsafe switch");
  a_radio_rc: assert property (
    !$past(srst) && !$past(status.asleep) && !status.asleep && !$past(status.hs_on_xtal) && !$past(status.xtal_enable)
    |-> clk_out.radio == $past(rc_osc_in)) else $error("radio not from rc");
  a_radio_xtal: assert property (
    $past(status.hs_on_xtal) && status.hs_on_xtal |-> clk_out.radio == $past(xtal_osc_in)) else $error("radio not xtal");
  a_lf_path: assert property (
    !$past(srst) |-> clk_out.wake_timer == ($past(status.lf_on_ext) ? $past(lf_ext_in) : $past(lf_rc_in)))
    else $error("wake timer source wrong");
  a_trim_kept: assert property (
    !$past(srst) && !$past(cal_load) |-> $stable(rc_trim)) else $error("trim changed");
  a_cal_loaded: assert property (
    cal_load |=> status.cal_valid && (rc_trim == $past(cal_trim))) else $error("trim not loaded");
endmodule : clock_select_asserts
bind system_clock_selector clock_select_asserts clock_select_asserts_inst (
  .clock, .srst, .rc_osc_in, .xtal_osc_in, .xtal_amp_ok, .lf_rc_in, .lf_ext_in,
  .wake_mode, .cal_load, .cal_trim, .clk_out, .status, .rc_trim
);
`default_nettype wire

/* bench/osc_cells.sv */
// Behavioural oscillator cells on the far side of the clock selector.
`timescale 1ns/1ps
`default_nettype none
module osc_cells (
  input wire logic clock,
  input wire logic xtal_enable,
  input wire logic amp_allow,
  output logic rc_osc_in,
  output logic xtal_osc_in,
  output logic xtal_amp_ok,
  output logic lf_rc_in,
  output logic lf_ext_in
);
  logic [2:0] rc_ff = 3'h0;
  logic [4:0] lf_ff = 5'h00;
  logic [4:0] amp_ff = 5'h00;
  // Fast RC, crystal and both low-speed sources.
  always @(posedge clock) begin
    rc_ff <= (rc_ff == 3'h5) ? 3'h0 : rc_ff + 3'h1;
    lf_ff <= lf_ff + 5'h01;
  end
  assign rc_osc_in = rc_ff < 3'h3;
  assign xtal_osc_in = xtal_enable & lf_ff[1];
  assign lf_rc_in = lf_ff[3];
  assign lf_ext_in = lf_ff[4];
  always @(posedge clock) begin
    if (!xtal_enable) begin
      amp_ff <= 5'h00;
    end else if (amp_allow && amp_ff != 5'h14) begin
      amp_ff <= amp_ff + 5'h01;
    end
  end
  assign xtal_amp_ok = amp_ff == 5'h14;
endmodule : osc_cells
`default_nettype wire

/* bench/test_system_clock_selector.sv */
// Self-checking testbench for the system clock selector.
`timescale 1ns/1ps
`default_nettype none
module test_system_clock_selector;
  typedef struct packed {logic [2:0] code; logic [7:0] exp;} div_row_t;
  logic clock = 1'b0, srst = 1'b1, sleep_req = 1'b0, wake_req = 1'b0, amp_allow = 1'b1;
  logic xtal_switch_req = 1'b0, lf_ext_select = 1'b0, cal_load = 1'b0;
  logic [2:0] cpu_div_sel = 3'h0;
  logic [7:0] cal_trim = 8'h00, got, rc_trim;
  logic rc_osc_in, xtal_osc_in, xtal_amp_ok, lf_rc_in, lf_ext_in;
  clock_select_pkg::wake_mode_t wake_mode = clock_select_pkg::WAKE_STAY_RC;
  clock_select_pkg::clk_out_t clk_out;
  clock_select_pkg::clk_status_t status;
  int fails = 0, total_checks = 0;
  div_row_t rows [8] = '{'{3'h0, 8'h01}, '{3'h1, 8'h02}, '{3'h2, 8'h04}, '{3'h3, 8'h08},
                         '{3'h4, 8'h10}, '{3'h5, 8'h20}, '{3'h6, 8'h20}, '{3'h7, 8'h20}};
  system_clock_selector system_clock_selector_inst (.clock, .srst, .rc_osc_in, .xtal_osc_in, .xtal_amp_ok,
    .lf_rc_in, .lf_ext_in, .sleep_req, .wake_req, .wake_mode, .xtal_switch_req, .cpu_div_sel, .lf_ext_select,
    .cal_load, .cal_trim, .clk_out, .status, .rc_trim);
  osc_cells osc_cells_inst (.clock, .xtal_enable(status.xtal_enable), .amp_allow, .rc_osc_in, .xtal_osc_in,
    .xtal_amp_ok, .lf_rc_in, .lf_ext_in);
  always #2 clock = ~clock;
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] seen);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
  endtask : tick
  // Counts radio rises up to the next rise of the periph or cpu clock.
  task automatic rises(input bit per, output logic [7:0] n);
    logic r0, c0;
    #1;
    n = 8'h00;
    r0 = clk_out.radio;
    c0 = per ? clk_out.periph : clk_out.cpu;
    repeat (600) begin
      @(posedge clock);
      #1;
      if (clk_out.radio && !r0) n++;
      r0 = clk_out.radio;
      if ((per ? clk_out.periph : clk_out.cpu) && !c0) break;
      c0 = per ? clk_out.periph : clk_out.cpu;
    end
  endtask : rises
  task automatic sleep_wake(input clock_select_pkg::wake_mode_t m);
    @(posedge clock) sleep_req <= 1'b1;
    @(posedge clock) sleep_req <= 1'b0;
    wake_mode <= m;
    #1;
    check("asleep", 8'h01, 8'(status.asleep));
    tick(4);
    @(posedge clock) wake_req <= 1'b1;
    @(posedge clock) wake_req <= 1'b0;
    #1;
    check("asleep", 8'h00, 8'(status.asleep));
    check("hs", 8'h00, 8'(status.hs_on_xtal));
  endtask : sleep_wake
  task automatic wait_on(input bit lf);
    repeat (400) begin
      #1;
      if ((lf ? status.lf_on_ext : status.hs_on_xtal) === 1'b1) break;
      @(posedge clock);
    end
  endtask : wait_on
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : final_report
  initial begin
    #100000;
    fails++;
    final_report();
  end
  initial begin
    tick(3);
    srst <= 1'b0;
    tick(2);
    #1;
    check("hs", 8'h00, 8'(status.hs_on_xtal));
    check("lf", 8'h00, 8'(status.lf_on_ext));
    check("trim", 8'h00, rc_trim);
    check("cal_valid", 8'h00, 8'(status.cal_valid));
    check("asleep", 8'h00, 8'(status.asleep));
    $display("reset test done");
    foreach (rows[i]) begin
      @(posedge clock) cpu_div_sel <= rows[i].code;
      tick(220);
      rises(1'b0, got);
      rises(1'b0, got);
      check("cpu ratio", rows[i].exp, got);
    end
    rises(1'b1, got);
    rises(1'b1, got);
    check("periph ratio", 8'h02, got);
    $display("divider test done");
    @(posedge clock) xtal_switch_req <= 1'b1;
    cal_trim <= 8'ha5;
    cal_load <= 1'b1;
    @(posedge clock) xtal_switch_req <= 1'b0;
    cal_load <= 1'b0;
    tick(60);
    #1;
    check("xtal_enable", 8'h00, 8'(status.xtal_enable));
    check("trim", 8'ha5, rc_trim);
    check("cal_valid", 8'h01, 8'(status.cal_valid));
    $display("stay rc test done");
    // Radio stays on the RC clock until the crystal is requested.
    sleep_wake(clock_select_pkg::WAKE_MANUAL);
    tick(60);
    #1;
    check("hs", 8'h00, 8'(status.hs_on_xtal));
    @(posedge clock) xtal_switch_req <= 1'b1;
    @(posedge clock) xtal_switch_req <= 1'b0;
    wait_on(1'b0);
    check("hs", 8'h01, 8'(status.hs_on_xtal));
    $display("manual test done");
    @(posedge clock) amp_allow <= 1'b0;
    sleep_wake(clock_select_pkg::WAKE_AUTO);
    tick(60);
    #1;
    check("xtal_enable", 8'h01, 8'(status.xtal_enable));
    check("hs", 8'h00, 8'(status.hs_on_xtal));
    @(posedge clock) amp_allow <= 1'b1;
    wait_on(1'b0);
    check("hs", 8'h01, 8'(status.hs_on_xtal));
    check("trim", 8'ha5, rc_trim);
    $display("auto test done");
    @(posedge clock) lf_ext_select <= 1'b1;
    @(posedge clock) lf_ext_select <= 1'b0;
    wait_on(1'b1);
    sleep_wake(clock_select_pkg::WAKE_STAY_RC);
    #1;
    check("lf", 8'h01, 8'(status.lf_on_ext));
    @(posedge clock) srst <= 1'b1;
    tick(3);
    srst <= 1'b0;
    tick(2);
    #1;
    check("lf", 8'h00, 8'(status.lf_on_ext));
    check("cal_valid", 8'h00, 8'(status.cal_valid));
    check("trim", 8'h00, rc_trim);
    $display("low speed test done");
    final_report();
  end
endmodule : test_system_clock_selector
`default_nettype wire

/* rtl/clock_select_pkg.sv */
// Constants, encodings and carrier types shared by the system clock selector.
`default_nettype none
package clock_select_pkg;

  // ****************************************
  // Nominal rates
  // ****************************************
  localparam int HS_NOMINAL_MHZ = 32;
  localparam int LF_NOMINAL_KHZ = 32;
  localparam int RC_DEFAULT_MHZ = 27;

  // ****************************************
  // Processor divider codes: the rate is 32 MHz shifted right by the code, by 5 at most
  // ****************************************
  localparam logic [2:0] CPU_DIV_1 = 3'h0;
  localparam logic [2:0] CPU_DIV_32 = 3'h5;
  localparam int CPU_CNT_W = 5;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [7:0] RC_TRIM_RESET = 8'h00;
  localparam logic [CPU_CNT_W-1:0] CPU_CNT_RESET = 5'h00;

  // ****************************************
  // Wake-up policy for the high-speed source
  // ****************************************
  typedef enum logic [1:0] {
    WAKE_AUTO = 2'h0,
    WAKE_MANUAL = 2'h1,
    WAKE_STAY_RC = 2'h2
  } wake_mode_t;

  // ****************************************
  // High-speed source sequencer states
  // ****************************************
  typedef enum logic [4:0] {
    HS_SLEEP = 5'h01,
    HS_RC = 5'h02,
    HS_WAIT_AMP = 5'h04,
    HS_SWITCH = 5'h08,
    HS_XTAL = 5'h10
  } hs_state_t;

  // ****************************************
  // Carriers
  // ****************************************
  typedef struct packed {
    logic radio;
    logic periph;
    logic cpu;
    logic wake_timer;
  } clk_out_t;

  typedef struct packed {
    logic hs_on_xtal;
    logic lf_on_ext;
    logic asleep;
    logic xtal_enable;
    logic cal_valid;
  } clk_status_t;

endpackage : clock_select_pkg

`default_nettype wire

/* rtl/system_clock_selector.sv */
// System clock selector: high-speed source sequencing, dividers and low-speed source choice.
//
// Operation
// - Wake-up timers run from the 32 kHz low-speed clock, everything else from the 32 MHz clock or a division of it.
// - The high-speed source is the crystal or the fast RC oscillator, the low-speed source the RC or an external clock.
// - The radio gets the selected high-speed clock undivided, the peripherals a half-rate version.
// - The processor clock is the high-speed clock divided by 1, 2, 4, 8, 16 or 32.
// - After every reset and every wake-up the fast RC oscillator is the initial high-speed source.
// - In automatic mode the source moves to the crystal once the crystal has started after wake-up.
// - In manual mode the RC source is kept until software requests the crystal.
// - In stay-RC mode the RC source is kept for the whole awake period until the next sleep.
// - The crystal amplitude-ready flag is checked before switching to the crystal.
// - The RC oscillator runs untrimmed at about 27 MHz until a software calibration trims it to 32 MHz.
// - The RC calibration trim is kept across speed changes and while the oscillator is disabled.
// - After reset the low-speed clock comes from the internal RC oscillator.
// - Once software selects another low-speed source it stays selected until the next reset.
`timescale 1ns/1ps
`default_nettype none

module system_clock_selector (
  input wire logic clock,
  input wire logic srst,
  input wire logic rc_osc_in,
  input wire logic xtal_osc_in,
  input wire logic xtal_amp_ok,
  input wire logic lf_rc_in,
  input wire logic lf_ext_in,
  input wire logic sleep_req,
  input wire logic wake_req,
  input wire clock_select_pkg::wake_mode_t wake_mode,
  input wire logic xtal_switch_req,
  input wire logic [2:0] cpu_div_sel,
  input wire logic lf_ext_select,
  input wire logic cal_load,
  input wire logic [7:0] cal_trim,
  output var clock_select_pkg::clk_out_t clk_out,
  output var clock_select_pkg::clk_status_t status,
  output logic [7:0] rc_trim
);

  // ****************************************
  // Functions
  // ****************************************

  // Clamps an out-of-range divider code to the slowest rate.
  function automatic logic [2:0] legal_div(input logic [2:0] code);
    legal_div = (code > clock_select_pkg::CPU_DIV_32) ? clock_select_pkg::CPU_DIV_32 : code;
  endfunction : legal_div

  // Processor clock level for a divider code, from the edge counter and the undivided level.
  function automatic logic cpu_level(input logic [2:0] code, input logic [4:0] cnt, input logic hs);
    if (code == clock_select_pkg::CPU_DIV_1) begin
      cpu_level = hs;
    end else begin
      cpu_level = cnt[code - 3'h1];
    end
  endfunction : cpu_level

  // ****************************************
  // State
  // ****************************************
  clock_select_pkg::hs_state_t hs_state_ff;
  clock_select_pkg::hs_state_t nxt_hs_state;
  logic hs_sel_xtal_ff;
  logic hs_level_ff;
  logic hs_prev_ff;
  logic periph_ff;
  logic [4:0] cpu_cnt_ff;
  logic [2:0] cpu_div_ff;
  logic cpu_ff;
  logic switch_req_ff;
  logic lf_sel_ext_ff;
  logic lf_use_ext_ff;
  logic lf_level_ff;
  logic [7:0] rc_trim_ff;
  logic cal_valid_ff;
  logic hs_rise;
  logic hs_safe;
  logic xtal_wanted;

  assign hs_rise = hs_level_ff & ~hs_prev_ff;
  // Both sources low and the output low: a change here cannot cut a pulse short.
  assign hs_safe = ~rc_osc_in & ~xtal_osc_in & ~hs_level_ff;
  assign xtal_wanted = (wake_mode == clock_select_pkg::WAKE_AUTO) ||
                       ((wake_mode == clock_select_pkg::WAKE_MANUAL) && switch_req_ff);

  // ****************************************
  // High-speed source sequencer
  // ****************************************
  always_comb begin
    nxt_hs_state = hs_state_ff;
    unique case (hs_state_ff)
      clock_select_pkg::HS_SLEEP: begin
        if (wake_req) begin
          nxt_hs_state = clock_select_pkg::HS_RC;
        end
      end
      clock_select_pkg::HS_RC: begin
        if (sleep_req) begin
          nxt_hs_state = clock_select_pkg::HS_SLEEP;
        end else if (xtal_wanted) begin
          nxt_hs_state = clock_select_pkg::HS_WAIT_AMP;
        end
      end
      clock_select_pkg::HS_WAIT_AMP: begin
        if (sleep_req) begin
          nxt_hs_state = clock_select_pkg::HS_SLEEP;
        end else if (xtal_amp_ok) begin
          nxt_hs_state = clock_select_pkg::HS_SWITCH;
        end
      end
      clock_select_pkg::HS_SWITCH: begin
        if (sleep_req) begin
          nxt_hs_state = clock_select_pkg::HS_SLEEP;
        end else if (hs_safe) begin
          nxt_hs_state = clock_select_pkg::HS_XTAL;
        end
      end
      clock_select_pkg::HS_XTAL: begin
        if (sleep_req) begin
          nxt_hs_state = clock_select_pkg::HS_SLEEP;
        end
      end
      default: begin
        nxt_hs_state = clock_select_pkg::HS_RC;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hs_state_ff <= clock_select_pkg::HS_RC;
    end else begin
      hs_state_ff <= nxt_hs_state;
    end
  end

  // Manual request is sticky until sleep; a request in the sleep cycle is still kept.
  always_ff @(posedge clock) begin
    if (srst) begin
      switch_req_ff <= 1'b0;
    end else if (xtal_switch_req) begin
      switch_req_ff <= 1'b1;
    end else if (sleep_req) begin
      switch_req_ff <= 1'b0;
    end
  end

  // ****************************************
  // Source mux
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      hs_sel_xtal_ff <= 1'b0;
    end else if (nxt_hs_state != clock_select_pkg::HS_XTAL) begin
      hs_sel_xtal_ff <= 1'b0;
    end else if (hs_safe) begin
      hs_sel_xtal_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      hs_level_ff <= 1'b0;
      hs_prev_ff <= 1'b0;
    end else begin
      if (hs_state_ff == clock_select_pkg::HS_SLEEP) begin
        hs_level_ff <= 1'b0;
      end else if (hs_sel_xtal_ff) begin
        hs_level_ff <= xtal_osc_in;
      end else begin
        hs_level_ff <= rc_osc_in;
      end
      hs_prev_ff <= hs_level_ff;
    end
  end

  // ****************************************
  // Dividers
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      periph_ff <= 1'b0;
      cpu_cnt_ff <= clock_select_pkg::CPU_CNT_RESET;
    end else if (hs_rise) begin
      periph_ff <= ~periph_ff;
      cpu_cnt_ff <= cpu_cnt_ff + 5'h01;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_div_ff <= clock_select_pkg::CPU_DIV_1;
    end else if ((cpu_cnt_ff == clock_select_pkg::CPU_CNT_RESET) && !hs_level_ff) begin
      cpu_div_ff <= legal_div(cpu_div_sel);
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      cpu_ff <= 1'b0;
    end else begin
      cpu_ff <= cpu_level(cpu_div_ff, cpu_cnt_ff, hs_level_ff);
    end
  end

  // ****************************************
  // Low-speed source
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      lf_sel_ext_ff <= 1'b0;
    end else if (lf_ext_select) begin
      lf_sel_ext_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lf_use_ext_ff <= 1'b0;
    end else if (lf_sel_ext_ff && !lf_rc_in && !lf_ext_in && !lf_level_ff) begin
      lf_use_ext_ff <= 1'b1;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      lf_level_ff <= 1'b0;
    end else begin
      lf_level_ff <= lf_use_ext_ff ? lf_ext_in : lf_rc_in;
    end
  end

  // ****************************************
  // RC calibration trim
  // ****************************************
  always_ff @(posedge clock) begin
    if (srst) begin
      rc_trim_ff <= clock_select_pkg::RC_TRIM_RESET;
      cal_valid_ff <= 1'b0;
    end else if (cal_load) begin
      rc_trim_ff <= cal_trim;
      cal_valid_ff <= 1'b1;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // undivided radio clock
  assign clk_out.radio = hs_level_ff;
  assign clk_out.periph = periph_ff;
  assign clk_out.cpu = cpu_ff;
  assign clk_out.wake_timer = lf_level_ff;
  assign status.hs_on_xtal = hs_sel_xtal_ff;
  assign status.lf_on_ext = lf_use_ext_ff;
  assign status.asleep = (hs_state_ff == clock_select_pkg::HS_SLEEP);
  assign status.xtal_enable = (hs_state_ff == clock_select_pkg::HS_WAIT_AMP) ||
                              (hs_state_ff == clock_select_pkg::HS_SWITCH) ||
                              (hs_state_ff == clock_select_pkg::HS_XTAL);
  assign status.cal_valid = cal_valid_ff;
  assign rc_trim = rc_trim_ff;

endmodule : system_clock_selector

`default_nettype wire
